// file: verilog/pclp_pkg.sv
/*
 * Package of the parallel configuration load port: timing counts, scheme
 * encodings and the state carriers shared by the loader and its serializer.
 * Assumes a 25 MHz system clock.
 */
package pclp_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int BUSY_MAX_NS = 4000;
    localparam int BUSY_MAX_CYC = BUSY_MAX_NS / CLK_PERIOD_NS;
    localparam int STATUS_MAX_NS = 1000;
    localparam int STATUS_MAX_CYC = STATUS_MAX_NS / CLK_PERIOD_NS;
    localparam int SER_HALF_NS = 80;
    localparam int SER_HALF_CYC = (SER_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BITS_PER_BYTE = 8;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [3:0] BITCNT_RST = 4'h0;

    typedef enum logic {PCLP_SYNC, PCLP_ASYNC} pclp_scheme_t;

    typedef struct packed {
        logic [7:0] data;
        logic valid;
    } pclp_byte_t;

    typedef struct packed {
        logic bit_val;
        logic valid;
    } pclp_bit_t;
endpackage : pclp_pkg

// file: verilog/pclp_serializer.sv
/*
 * Byte serializer of the configuration load port. Shifts a loaded byte out
 * LSB first, one bit per falling edge of the internal serializing clock, or of the host clock in external mode.
 * Assumes load only while idle; ce freezes all state.
 */
`timescale 1ns/1ps
module pclp_serializer (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire pclp_pkg::pclp_byte_t load_i,
    input wire logic ext_fall_i,
    input wire logic use_ext_i,
    output pclp_pkg::pclp_bit_t bit_o,
    output logic busy_o,
    output logic done_o
);
    typedef struct packed {
        logic [7:0] shreg;
        logic [3:0] left;
        logic [1:0] div;
        logic sclk;
        pclp_pkg::pclp_bit_t bit_out;
        logic last;
    } pclp_ser_st_t;

    pclp_ser_st_t st;
    pclp_ser_st_t next_st;
    logic fall;

    // The divider is two bits wide, so longer half periods cannot be served.
    if (pclp_pkg::SER_HALF_CYC < 1 || pclp_pkg::SER_HALF_CYC > 4) begin : g_bad_half
        $error("SER_HALF_CYC must fit the two-bit divider");
    end

    // Internal oscillator toggles every SER_HALF_CYC cycles; the external mode
    // follows falling edges of the host clock instead.
    always_comb begin
        next_st = st;
        next_st.bit_out.valid = 1'b0;
        next_st.last = 1'b0;
        fall = 1'b0;
        if (use_ext_i) begin
            fall = ext_fall_i;
        end else if (st.left != pclp_pkg::BITCNT_RST) begin
            if (st.div == 2'(pclp_pkg::SER_HALF_CYC - 1)) begin
                next_st.div = 2'h0;
                next_st.sclk = ~st.sclk;
                fall = st.sclk;
            end else begin
                next_st.div = st.div + 2'h1;
            end
        end
        if (load_i.valid) begin
            next_st.shreg = load_i.data;
            next_st.left = 4'(pclp_pkg::BITS_PER_BYTE);
            next_st.div = 2'h0;
            next_st.sclk = 1'b1;
        end else if (fall && st.left != pclp_pkg::BITCNT_RST) begin
            next_st.bit_out.bit_val = st.shreg[0];
            next_st.bit_out.valid = 1'b1;
            next_st.shreg = {1'b0, st.shreg[7:1]};
            next_st.left = st.left - 4'h1;
            next_st.last = (st.left == 4'h1);
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    assign bit_o = st.bit_out;
    assign busy_o = (st.left != pclp_pkg::BITCNT_RST);
    assign done_o = st.last;
endmodule : pclp_serializer

// file: verilog/pclp_top.sv
/*
 * Parallel configuration load port, device side. Takes configuration bytes
 * in the synchronous scheme (host config clock) or the asynchronous scheme
 * (chip selects and write strobe), serializes them and reports ready/busy.
 * Assumes pins are asynchronous; all but scheme_async_i pass a two-stage synchronizer; the
 * restart pin is sampled too, and the system reset rst_i is separate.
 */
// Operation
// - Sync: capture on rise, shift eight falls.
// - Sync: new byte every eighth rising edge.
// - Async writes only while both selects asserted.
// - Async: capture on write rise, serialize internally.
// - Busy low within 50 ns, held processing; here three clocks (up to 120 ns) after write rise.
// - Ready returns on eighth internal falling edge.
// - Busy indication lasts at most 4 us.
// - Read strobe puts ready on bit 7.
// - Load complete rises after all data loaded.
// - Restart low drops status and complete quickly.
`timescale 1ns/1ps
module pclp_top #(
    parameter int TOTAL_BYTES = 16
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic scheme_async_i,
    input wire logic restart_n_i,
    input wire logic config_clock_i,
    input wire logic [7:0] data_i,
    input wire logic select_low_i,
    input wire logic select_high_i,
    input wire logic write_strobe_n_i,
    input wire logic read_strobe_n_i,
    output logic byte_in_bit7_o,
    output logic byte_in_bit7_oe_o,
    output logic ready_busy_o,
    output logic load_status_n_o,
    output logic load_complete_o,
    output logic serial_bit_o,
    output logic serial_valid_o
);
    localparam int CNT_W = $clog2(TOTAL_BYTES + 1);

    // A load of zero bytes could never raise completion, so refuse it.
    if (TOTAL_BYTES < 1) begin : g_bad_total
        $error("TOTAL_BYTES must be at least one");
    end

    typedef enum logic [1:0] {PCLP_RESTART, PCLP_LOADING, PCLP_DONE} pclp_state_t;

    typedef struct packed {
        logic [1:0] s_rst;
        logic [1:0] s_clk;
        logic [1:0] s_ws;
        logic [1:0] s_rs;
        logic [1:0] s_csl;
        logic [1:0] s_csh;
        logic [15:0] s_dat;
        logic clk_d;
        logic ws_d;
        logic [2:0] phase;
        logic [CNT_W-1:0] bytes;
        pclp_state_t state;
        logic ready;
        logic status_n;
        logic complete;
        logic d7;
        logic d7_oe;
        logic ser_bit;
        logic ser_val;
        pclp_pkg::pclp_byte_t load;
    } pclp_st_t;

    pclp_st_t st;
    pclp_st_t next_st;
    pclp_pkg::pclp_bit_t ser_bit;
    logic ser_done;

    // Sync and async falls or completions all flow through the serializer.
    pclp_serializer u_ser (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .load_i(st.load),
        .ext_fall_i(st.clk_d && !st.s_clk[1]),
        .use_ext_i(!scheme_async_i),
        .bit_o(ser_bit),
        .busy_o(),
        .done_o(ser_done)
    );

    function automatic logic rose(input logic now, input logic was);
        rose = now && !was;
    endfunction : rose

    // Main sequencing: synchronizers, byte capture, handshake and completion.
    always_comb begin
        logic sel;
        logic ws_rise;
        sel = 1'b0;
        ws_rise = 1'b0;
        next_st = st;
        next_st.s_rst = {st.s_rst[0], restart_n_i};
        next_st.s_clk = {st.s_clk[0], config_clock_i};
        next_st.s_ws = {st.s_ws[0], write_strobe_n_i};
        next_st.s_rs = {st.s_rs[0], read_strobe_n_i};
        next_st.s_csl = {st.s_csl[0], select_low_i};
        next_st.s_csh = {st.s_csh[0], select_high_i};
        next_st.s_dat = {st.s_dat[7:0], data_i};
        next_st.clk_d = st.s_clk[1];
        next_st.ws_d = st.s_ws[1];
        next_st.load.valid = 1'b0;
        next_st.ser_bit = ser_bit.bit_val;
        next_st.ser_val = ser_bit.valid;
        sel = !st.s_csl[1] && st.s_csh[1];
        ws_rise = rose(st.s_ws[1], st.ws_d) && sel;
        // Read strobe drives ready onto bit 7 only while selected.
        next_st.d7_oe = sel && !st.s_rs[1] && scheme_async_i;
        next_st.d7 = st.ready;
        if (!st.s_rst[1]) begin
            next_st.state = PCLP_RESTART;
            next_st.status_n = 1'b0;
            next_st.complete = 1'b0;
            next_st.ready = 1'b1;
            next_st.phase = 3'h0;
            next_st.bytes = '0;
        end else begin
            next_st.status_n = 1'b1;
            unique case (st.state)
                PCLP_RESTART: begin
                    next_st.state = PCLP_LOADING;
                end
                PCLP_LOADING: begin
                    if (!scheme_async_i && rose(st.s_clk[1], st.clk_d)) begin
                        // Byte taken only on the first of each eight rising edges.
                        next_st.phase = st.phase + 3'h1;
                        if (st.phase == 3'h0) begin
                            next_st.load.data = st.s_dat[15:8];
                            next_st.load.valid = 1'b1;
                            next_st.bytes = st.bytes + CNT_W'(1);
                        end
                    end
                    if (scheme_async_i && ws_rise && st.ready) begin
                        next_st.load.data = st.s_dat[15:8];
                        next_st.load.valid = 1'b1;
                        next_st.ready = 1'b0;
                        next_st.bytes = st.bytes + CNT_W'(1);
                    end
                    if (ser_done) begin
                        next_st.ready = 1'b1;
                        if (st.bytes == CNT_W'(TOTAL_BYTES)) begin
                            next_st.state = PCLP_DONE;
                            next_st.complete = 1'b1;
                        end
                    end
                end
                PCLP_DONE: begin
                    next_st.complete = 1'b1;
                end
                default: begin
                    next_st.state = PCLP_RESTART;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '{s_rst: 2'h0, s_clk: 2'h0, s_ws: 2'h3, s_rs: 2'h3, s_csl: 2'h3,
                    s_csh: 2'h0, s_dat: 16'h0000, clk_d: 1'b0, ws_d: 1'b1,
                    phase: 3'h0, bytes: '0, state: PCLP_RESTART, ready: 1'b1,
                    status_n: 1'b0, complete: 1'b0, d7: 1'b0, d7_oe: 1'b0,
                    ser_bit: 1'b0, ser_val: 1'b0,
                    load: '{data: pclp_pkg::BYTE_RST, valid: 1'b0}};
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    assign byte_in_bit7_o = st.d7;
    assign byte_in_bit7_oe_o = st.d7_oe;
    assign ready_busy_o = st.ready;
    assign load_status_n_o = st.status_n;
    assign load_complete_o = st.complete;
    assign serial_bit_o = st.ser_bit;
    assign serial_valid_o = st.ser_val;

    // Busy never outlasts the 4 us ceiling; counted in helper logic.
    logic [7:0] busy_cnt;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_cnt <= 8'h00;
        end else if (ce_i) begin
            busy_cnt <= st.ready ? 8'h00 : busy_cnt + 8'h01;
        end
    end

    a_busy_bounded: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        busy_cnt <= 8'(pclp_pkg::BUSY_MAX_CYC))
        else $error("busy held too long");
    a_busy_after_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && st.state == PCLP_LOADING && scheme_async_i && st.ready && st.s_rst[1]
        && rose(st.s_ws[1], st.ws_d) && !st.s_csl[1] && st.s_csh[1] |=> !ready_busy_o)
        else $error("busy not raised after write");
    a_restart_drop: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && !st.s_rst[1] |=> !load_status_n_o && !load_complete_o)
        else $error("restart did not drop status");
    a_bit7_release: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (st.s_csl[1] || !st.s_csh[1]) && ce_i |=> !byte_in_bit7_oe_o)
        else $error("bit 7 driven while unselected");
    a_bit7_status: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        byte_in_bit7_oe_o && $stable(ready_busy_o) |-> byte_in_bit7_o == ready_busy_o)
        else $error("bit 7 does not carry ready");
    a_ready_return: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ce_i && ser_done && st.s_rst[1] |=> ready_busy_o)
        else $error("ready not restored");
    a_complete_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        load_complete_o && st.s_rst[1] && ce_i |=> load_complete_o)
        else $error("complete dropped without restart");
    a_sync_capture: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        st.load.valid && !scheme_async_i |-> st.phase == 3'h1)
        else $error("sync byte taken off phase");
endmodule : pclp_top

// file: sim/pclp_host_model.sv
/*
 * Host model for the load port: drives restart, config clock, data bus,
 * selects and strobes. Assumes the bench clock; all changes at its falling edge.
 */
`timescale 1ns/1ps
module pclp_host_model (
    input wire logic sys_clk_i,
    output logic restart_n_o,
    output logic config_clock_o,
    output logic [7:0] data_o,
    output logic select_low_o,
    output logic select_high_o,
    output logic write_strobe_n_o,
    output logic read_strobe_n_o
);
    // Idle levels; the config clock stands low outside bytes.
    initial begin
        restart_n_o = 1'b1;
        config_clock_o = 1'b0;
        data_o = 8'h00;
        select_low_o = 1'b1;
        select_high_o = 1'b0;
        write_strobe_n_o = 1'b1;
        read_strobe_n_o = 1'b1;
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask : wait_n

    // Restart low 10 us, then 5.2 us of quiet before any clock or strobe.
    task automatic restart();
        restart_n_o = 1'b0;
        wait_n(250);
        restart_n_o = 1'b1;
        wait_n(130);
    endtask : restart

    // Eight 320 ns clock cycles per byte; the byte is valid only around the
    // first rise, so a device that latches on other rises takes the wrong value.
    task automatic sync_byte(input logic [7:0] b);
        data_o = b;
        wait_n(2);
        for (int i = 0; i < 8; i++) begin
            config_clock_o = 1'b1;
            wait_n(4);
            config_clock_o = 1'b0;
            data_o = ~b;
            wait_n(4);
        end
    endtask : sync_byte

    // Write strobe low 520 ns; data inverted once its hold time has run out.
    task automatic async_write(input logic [7:0] b, input logic sel);
        data_o = b;
        select_low_o = 1'b0;
        select_high_o = sel;
        wait_n(2);
        write_strobe_n_o = 1'b0;
        wait_n(13);
        write_strobe_n_o = 1'b1;
        wait_n(1);
        data_o = ~b;
    endtask : async_write

    task automatic set_read(input logic lvl);
        read_strobe_n_o = lvl;
    endtask : set_read
endmodule : pclp_host_model

// file: sim/testbench.sv
/*
 * Self-checking bench of the load port: sync and async loading, read strobe
 * status and restart. The host model drives the host pins; the bench drives rst_i and scheme_async_i.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
    logic sys_clk_i, rst_i, scheme_async_i;
    logic restart_n, cfg_clk, sel_l, sel_h, wr_n, rd_n;
    logic bit7, bit7_oe, ready_busy, status_n, complete, ser_bit, ser_valid;
    logic [7:0] host_d, shreg;
    wire logic [7:0] data_bus;
    int nbits, err_count, n_checks;

    // Bit 7 is shared: the device wins while it drives, else the host.
    assign data_bus = {bit7_oe ? bit7 : host_d[7], host_d[6:0]};

    pclp_host_model pclp_host_model_inst (.sys_clk_i(sys_clk_i), .restart_n_o(restart_n),
        .config_clock_o(cfg_clk), .data_o(host_d), .select_low_o(sel_l),
        .select_high_o(sel_h), .write_strobe_n_o(wr_n), .read_strobe_n_o(rd_n));
    pclp_top #(.TOTAL_BYTES(2)) pclp_top_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .ce_i(1'b1), .scheme_async_i(scheme_async_i), .restart_n_i(restart_n),
        .config_clock_i(cfg_clk), .data_i(data_bus), .select_low_i(sel_l),
        .select_high_i(sel_h), .write_strobe_n_i(wr_n), .read_strobe_n_i(rd_n),
        .byte_in_bit7_o(bit7), .byte_in_bit7_oe_o(bit7_oe), .ready_busy_o(ready_busy),
        .load_status_n_o(status_n), .load_complete_o(complete),
        .serial_bit_o(ser_bit), .serial_valid_o(ser_valid));

    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end

    // Serial bits arrive LSB first, so shifting in from the top rebuilds the byte.
    always @(posedge sys_clk_i) begin
        if (ser_valid === 1'b1) begin
            shreg <= {ser_bit, shreg[7:1]};
            nbits <= nbits + 1;
        end
    end

    task automatic start(input logic mode);
        scheme_async_i = mode;
        rst_i = 1'b1;
        repeat (6) @(negedge sys_clk_i);
        `CHK({ready_busy, status_n, complete, bit7_oe}, 4'h8);
        rst_i = 1'b0;
        pclp_host_model_inst.restart();
        nbits = 0;
    endtask : start

    // Two bytes with the bus changing after each first rise, then restart.
    task automatic sync_scen();
        logic [7:0] b;
        start(1'b0);
        for (int k = 0; k < 2; k++) begin
            b = k ? 8'h3C : 8'hA5;
            nbits = 0;
            pclp_host_model_inst.sync_byte(b);
            repeat (8) @(negedge sys_clk_i);
            `CHK(nbits, 8);
            `CHK(shreg, b);
            `CHK(complete, k ? 1'b1 : 1'b0);
        end
        fork
            pclp_host_model_inst.restart();
            begin
                repeat (25) @(negedge sys_clk_i);
                `CHK({status_n, complete}, 2'h0);
            end
        join
    endtask : sync_scen

    // Unselected write first, then two writes with a status read while busy.
    task automatic async_scen();
        int t;
        logic [7:0] b;
        start(1'b1);
        pclp_host_model_inst.async_write(8'h5A, 1'b0);
        repeat (8) @(negedge sys_clk_i);
        `CHK({ready_busy, nbits[3:0]}, 5'h10);
        for (int k = 0; k < 2; k++) begin
            b = k ? 8'h01 : 8'h96;
            nbits = 0;
            pclp_host_model_inst.async_write(b, 1'b1);
            repeat (4) @(negedge sys_clk_i);
            `CHK(ready_busy, 1'b0);
            repeat (8) @(negedge sys_clk_i);
            pclp_host_model_inst.set_read(1'b0);
            repeat (4) @(negedge sys_clk_i);
            `CHK({bit7_oe, data_bus[7]}, 2'h2);
            pclp_host_model_inst.set_read(1'b1);
            repeat (4) @(negedge sys_clk_i);
            `CHK(bit7_oe, 1'b0);
            for (t = 21; t < 120 && ready_busy !== 1'b1; t++) @(negedge sys_clk_i);
            `CHK(t < 100, 1'b1);
            // The last bit is counted a cycle after ready returns, so let it land first.
            repeat (2) @(negedge sys_clk_i);
            `CHK(nbits, 8);
            `CHK(shreg, b);
        end
        `CHK(complete, 1'b1);
        // An idle status read must show ready high on bit 7, not a stuck level.
        pclp_host_model_inst.set_read(1'b0);
        repeat (4) @(negedge sys_clk_i);
        `CHK({bit7_oe, data_bus[7]}, 2'h3);
        pclp_host_model_inst.set_read(1'b1);
        repeat (4) @(negedge sys_clk_i);
        `CHK(bit7_oe, 1'b0);
    endtask : async_scen

    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    // Both scenarios need well under 5000 cycles; 1 ms cuts a hang short.
    initial begin
        rst_i = 1'b1;
        scheme_async_i = 1'b0;
        nbits = 0;
        shreg = 8'h00;
        err_count = 0;
        n_checks = 0;
        fork
            begin
                #1000000;
                err_count++;
                final_report();
            end
        join_none
        sync_scen();
        async_scen();
        final_report();
    end
endmodule : testbench
